/* File: dv/coil_map_asserts.sv */
// port checker for the coil profile mapper
`timescale 1ns/1ns
module coil_map_asserts #(parameter int RELAYS = 6) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [1:0] profile_select,
    input wire logic bypass_system,
    input wire logic fieldbus_control_enable,
    input wire logic req_valid,
    input wire logic [7:0] req_function,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_value,
    input wire logic [31:0] control_word,
    input wire logic [RELAYS-1:0] relay_out,
    input wire logic [1:0] active_profile,
    input wire logic resp_valid,
    input wire logic resp_exception
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    wire logic wr1 = req_valid && req_function == 8'h05;
    wire logic on = wr1 && fieldbus_control_enable && req_value == 16'hFF00;
    wire logic [1:0] pick = bypass_system ? 2'h3 :
        (profile_select == 2'h3 ? 2'h0 : profile_select);
    a_read_served: assert property (
        req_valid && req_function == 8'h01 && req_addr == 16'h0000
        |=> resp_valid && !resp_exception) else $error("read refused");
    a_write_blocked: assert property (
        wr1 && !fieldbus_control_enable |=> resp_exception && $stable(relay_out)
    ) else $error("write taken while disabled");
    // guarded by the reset history: the reset edge loads zero, not the pick
    a_profile_pick: assert property (
        !$past(sys_rst) |-> active_profile == $past(pick)
    ) else $error("wrong active profile");
    a_limited_mask: assert property (
        active_profile == 2'h0 && $stable(active_profile)
        |-> (control_word & ~32'h000008EF) == 32'h0) else $error("lim bits");
    a_extended_mask: assert property (
        active_profile == 2'h1 && $stable(active_profile)
        |-> (control_word & ~32'h000FFFF7) == 32'h0) else $error("ext bits");
    a_full_mask: assert property (
        active_profile == 2'h2 && $stable(active_profile)
        |-> (control_word & ~32'h00000CFF) == 32'h0) else $error("full bits");
    a_coil_write: assert property (
        on && req_addr == 16'h0001 |=> control_word[1]) else $error("coil 2");
    a_relay_write: assert property (
        on && req_addr == 16'h0020 |=> relay_out[0]) else $error("relay one");
    c_relay: cover property (on && req_addr == 16'h0020);
    c_bypass: cover property (active_profile == 2'h3);
    c_refused: cover property (resp_valid && resp_exception);
endmodule : coil_map_asserts

/* File: dv/rtu_master_model.sv */
// request side of the serial master facing the mapper
`timescale 1ns/1ns
module rtu_master_model (
    input wire logic sys_clk,
    input wire logic resp_valid,
    input wire logic resp_exception,
    input wire logic [7:0] resp_code,
    input wire logic [15:0] resp_bits,
    output logic req_valid,
    output logic [7:0] req_function,
    output logic [15:0] req_addr,
    output logic [15:0] req_count,
    output logic [15:0] req_value
);
    logic rx_ok;
    logic rx_exc;
    logic [7:0] rx_code;
    logic [15:0] rx_bits;
    initial {req_valid, req_function, req_addr, req_count, req_value} = '0;
    // addresses go out zero based, set digit left out; codes 01/02/05/0F, and 03 as an unsupported code
    task automatic xfer(input logic [7:0] f, input logic [15:0] a, c, v);
        rx_ok = 1'b0;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_function <= f;
        req_addr <= a;
        req_count <= c;
        req_value <= v;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        // the answer stands one cycle, so it is taken at the next edge
        for (int i = 0; i < 4 && !rx_ok; i++) begin
            @(posedge sys_clk);
            rx_ok = resp_valid;
        end
        // a missing answer leaves unknowns, which every compare rejects
        rx_exc = rx_ok ? resp_exception : 1'bx;
        rx_code = rx_ok ? resp_code : 8'hXX;
        rx_bits = rx_ok ? resp_bits : 16'hXXXX;
    endtask : xfer
endmodule : rtu_master_model

/* File: dv/testbench.sv */
// self-checking bench for the coil profile mapper
`timescale 1ns/1ns
module testbench;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] profile_select = 2'h0;
    logic bypass_system = 1'b0;
    logic fieldbus_control_enable = 1'b0;
    logic [31:0] status_word = 32'hA5A51234;
    logic [5:0] digital_in = 6'h2D;
    logic [31:0] mask [3] = '{32'h000008EF, 32'h000FFFF7, 32'h00000CFF};
    wire logic req_valid, resp_valid, resp_exception;
    wire logic [7:0] req_function, resp_code;
    wire logic [15:0] req_addr, req_count, req_value, resp_bits;
    wire logic [31:0] control_word;
    wire logic [5:0] relay_out;
    wire logic [1:0] active_profile;
    wire logic [4:0] resp_bit_count;
    wire logic ramp_stop_n, coast_stop_n, emergency_stop_n;
    wire logic external_location_two;
    wire logic [3:0] stops = {ramp_stop_n, coast_stop_n, emergency_stop_n,
        external_location_two};
    int errors = 0;
    int compares = 0;
    always #5 sys_clk = ~sys_clk;
    rtu_master_model m (.sys_clk(sys_clk), .resp_valid(resp_valid),
        .resp_exception(resp_exception), .resp_code(resp_code),
        .resp_bits(resp_bits), .req_valid(req_valid),
        .req_function(req_function), .req_addr(req_addr),
        .req_count(req_count), .req_value(req_value));
    fieldbus_coil_profile_mapper DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .profile_select(profile_select), .bypass_system(bypass_system),
        .fieldbus_control_enable(fieldbus_control_enable),
        .status_word(status_word), .digital_in(digital_in),
        .req_valid(req_valid), .req_function(req_function),
        .req_addr(req_addr), .req_count(req_count), .req_value(req_value),
        .req_value_len_unused(2'h0), .control_word(control_word),
        .relay_out(relay_out), .active_profile(active_profile),
        .ramp_stop_n(ramp_stop_n), .coast_stop_n(coast_stop_n),
        .emergency_stop_n(emergency_stop_n),
        .external_location_two(external_location_two),
        .resp_valid(resp_valid),
        .resp_exception(resp_exception), .resp_code(resp_code),
        .resp_bits(resp_bits), .resp_bit_count(resp_bit_count));
    task check(input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task print_verdict;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        m.xfer(8'h05, 16'h0020, 16'h0001, 16'hFF00);
        check(active_profile, 32'h0);
        check({m.rx_exc, relay_out}, 32'h40);
        @(posedge sys_clk);
        fieldbus_control_enable <= 1'b1;
        m.xfer(8'h05, 16'h0020, 16'h0001, 16'hFF00);
        check(relay_out, 32'h01);
        m.xfer(8'h0F, 16'h0021, 16'h0005, 16'h001F);
        check(relay_out, 32'h3F);
        m.xfer(8'h01, 16'h0020, 16'h0006, 16'h0000);
        check(m.rx_bits, 32'h3F);
        check(resp_bit_count, 32'h06);
        m.xfer(8'h05, 16'h0020, 16'h0001, 16'h1234);
        check({m.rx_exc, m.rx_code, relay_out}, 32'h40FF);
        m.xfer(8'h05, 16'h0020, 16'h0001, 16'h0000);
        check(relay_out, 32'h3E);
        m.xfer(8'h01, 16'h0025, 16'h0002, 16'h0000);
        check(m.rx_code, 32'h02);
        check(resp_bit_count, 32'h00);
        m.xfer(8'h02, 16'h0020, 16'h0006, 16'h0000);
        check(m.rx_bits, 32'h2D);
        m.xfer(8'h03, 16'h0000, 16'h0001, 16'h0000);
        check({m.rx_exc, m.rx_code}, 32'h101);
        // all ones in the limited, extended and full profiles, so only the mask shapes the result
        for (int p = 0; p < 3; p++) begin
            @(posedge sys_clk);
            profile_select <= p[1:0];
            m.xfer(8'h0F, 16'h0000, 16'h0010, 16'hFFFF);
            m.xfer(8'h0F, 16'h0010, 16'h0010, 16'hFFFF);
            check(control_word, mask[p]);
            m.xfer(8'h01, 16'h0000, 16'h0010, 16'h0000);
            check(m.rx_bits, mask[p][15:0]);
            m.xfer(8'h02, 16'h0010, 16'h0010, 16'h0000);
            check(m.rx_bits, p == 1 ? 32'hA5A5 : 32'h0);
            check(stops, p == 1 ? 32'h1 : 32'hF);
        end
        m.xfer(8'h01, 16'h0014, 16'h000C, 16'h0000);
        check(m.rx_bits, 32'h0);
        @(posedge sys_clk);
        profile_select <= 2'h3;
        repeat (3) @(posedge sys_clk);
        check(active_profile, 32'h0);
        check(control_word, 32'h8EF);
        m.xfer(8'h05, 16'h0001, 16'h0001, 16'h0000);
        check(control_word, 32'h8ED);
        @(posedge sys_clk);
        bypass_system <= 1'b1;
        m.xfer(8'h05, 16'h0001, 16'h0001, 16'hFF00);
        check({active_profile, control_word[1]}, 32'h7);
        m.xfer(8'h0F, 16'h0000, 16'h0010, 16'hFFFF);
        check(control_word, 32'hFFFF);
        print_verdict();
    end
    initial begin
        repeat (2000) @(posedge sys_clk);
        errors++;
        print_verdict();
    end
endmodule : testbench
bind fieldbus_coil_profile_mapper coil_map_asserts #(.RELAYS(RELAYS)) chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .profile_select(profile_select),
    .bypass_system(bypass_system), .req_valid(req_valid),
    .fieldbus_control_enable(fieldbus_control_enable),
    .req_function(req_function), .req_addr(req_addr), .req_value(req_value),
    .control_word(control_word), .relay_out(relay_out),
    .active_profile(active_profile), .resp_valid(resp_valid),
    .resp_exception(resp_exception));

/* File: hw/bit_window.sv */
// bit selector: one bit of a flat vector at a zero-based address
`timescale 1ns/1ns
module bit_window #(
    parameter int WIDTH = 64
) (
    input wire logic [WIDTH-1:0] vec,
    input wire logic [15:0] addr,
    output logic hit,
    output logic value
);
    // zero-based: reference n+1 sits at address n
    assign hit = (32'(addr) < WIDTH);
    assign value = hit ? vec[addr[$clog2(WIDTH)-1:0]] : 1'b0;
endmodule : bit_window

/* File: hw/coil_map_defs.svh */
// constants for the coil and discrete-input profile mapper
`ifndef COIL_MAP_DEFS_SVH
`define COIL_MAP_DEFS_SVH
`define FC_READ_COILS 8'h01
`define FC_READ_INPUTS 8'h02
`define FC_WRITE_COIL 8'h05
`define FC_WRITE_COILS 8'h0F
`define WORD_BITS 32
`define RELAY_BASE 16'h0020
`define DI_BASE 16'h0020
`define PROF_LIMITED 2'h0
`define PROF_EXTENDED 2'h1
`define PROF_FULL 2'h2
`define MASK_LIMITED 32'h000008EF
`define MASK_FULL 32'h00000CFF
`define MASK_EXTENDED 32'h000FFFF7
`define MASK_BYPASS 32'h0000FFFF
`define COIL_ON 16'hFF00
`define COIL_OFF 16'h0000
`define EXC_FUNCTION 8'h01
`define EXC_ADDRESS 8'h02
`define EXC_VALUE 8'h03
`define CB_STOP_RAMP 0
`define CB_STOP_COAST 1
`define CB_STOP_EMERGENCY 2
`define CB_LOCATION_TWO 11
`define CB_EXT_STOP 0
`define CB_EXT_LOCATION_TWO 5
`define CB_EXT_EMERGENCY_MODE 8
`define CB_EXT_COAST_MODE 9
`endif

/* File: hw/coil_map_pkg.sv */
// types for the coil and discrete-input profile mapper
package coil_map_pkg;
    typedef enum logic [1:0] {
        PROFILE_LIMITED = 2'h0,
        PROFILE_EXTENDED = 2'h1,
        PROFILE_FULL = 2'h2,
        PROFILE_BYPASS = 2'h3
    } profile_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SCAN = 2'h1,
        ST_DONE = 2'h2
    } state_t;
endpackage : coil_map_pkg

/* File: hw/fieldbus_coil_profile_mapper.sv */
// coil and discrete-input mapping with profile selection
`timescale 1ns/1ns
`include "coil_map_defs.svh"
module fieldbus_coil_profile_mapper #(
    parameter int RELAYS = 6,
    parameter int DIGITAL_INPUTS = 6
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [1:0] profile_select,
    input wire logic bypass_system,
    input wire logic fieldbus_control_enable,
    input wire logic [31:0] status_word,
    input wire logic [DIGITAL_INPUTS-1:0] digital_in,
    input wire logic req_valid,
    input wire logic [7:0] req_function,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_count,
    input wire logic [15:0] req_value,
    input wire logic [1:0] req_value_len_unused,
    output logic [31:0] control_word,
    output logic [RELAYS-1:0] relay_out,
    output logic [1:0] active_profile,
    output logic ramp_stop_n,
    output logic coast_stop_n,
    output logic emergency_stop_n,
    output logic external_location_two,
    output logic resp_valid,
    output logic resp_exception,
    output logic [7:0] resp_code,
    output logic [15:0] resp_bits,
    output logic [4:0] resp_bit_count
);
    localparam int CW = 32 + RELAYS;
    localparam int DW = 32 + DIGITAL_INPUTS;

    logic [31:0] control_q, control_d;
    logic [RELAYS-1:0] relay_q, relay_d;
    logic [1:0] active_q;
    logic [31:0] status_q;
    logic [DIGITAL_INPUTS-1:0] di_q;
    logic resp_valid_q, resp_exc_q;
    logic [7:0] resp_code_q;
    logic [15:0] resp_bits_q, resp_bits_d;
    logic [4:0] resp_cnt_q;
    logic sig_rs_q, sig_cs_q, sig_es_q, sig_ext_q;

    // bypass wins over the profile_select input; the pick is registered in active_q
    wire coil_map_pkg::profile_t prof_w =
        bypass_system ? coil_map_pkg::PROFILE_BYPASS :
        (profile_select == `PROF_EXTENDED) ? coil_map_pkg::PROFILE_EXTENDED :
        (profile_select == `PROF_FULL) ? coil_map_pkg::PROFILE_FULL :
        coil_map_pkg::PROFILE_LIMITED;

    // writable bits of the control word per profile
    wire [31:0] mask_w =
        (active_q == coil_map_pkg::PROFILE_EXTENDED) ? `MASK_EXTENDED :
        (active_q == coil_map_pkg::PROFILE_FULL) ? `MASK_FULL :
        (active_q == coil_map_pkg::PROFILE_BYPASS) ? `MASK_BYPASS :
        `MASK_LIMITED;

    // status word is 16 bits outside the extended profile
    wire [31:0] status_w = (active_q == coil_map_pkg::PROFILE_EXTENDED) ?
        status_word : {16'h0000, status_word[15:0]};

    // coil and input images, relays and inputs from address 32
    wire [CW-1:0] coil_img = {relay_q, control_q & mask_w};
    // inputs and status share one sample, so a read never mixes two instants
    wire [DW-1:0] di_img = {di_q, status_q};

    wire is_rd_coil = (req_function == `FC_READ_COILS);
    wire is_rd_di = (req_function == `FC_READ_INPUTS);
    wire is_wr_one = (req_function == `FC_WRITE_COIL);
    wire is_wr_many = (req_function == `FC_WRITE_COILS);
    wire is_read = is_rd_coil | is_rd_di;
    wire is_write = is_wr_one | is_wr_many;
    // only 01, 05, 0F reach coils; 02 reaches inputs
    wire fc_ok = is_read | is_write;
    wire [15:0] count_w = is_wr_one ? 16'h0001 : req_count;
    wire [16:0] last_w = {1'b0, req_addr} + {1'b0, count_w} - 17'h00001;
    wire range_ok = (count_w != 16'h0000) && (count_w <= 16'h0010) &&
        (last_w < (is_rd_di ? 17'(DW) : 17'(CW)));
    wire value_ok = !is_wr_one ||
        (req_value == `COIL_ON) || (req_value == `COIL_OFF);

    // read: gather up to 16 bits from the addressed image
    logic [15:0] rd_bits;
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_rd
            logic ch, cv, dh, dv;
            wire [15:0] a = req_addr + 16'(g);
            bit_window #(.WIDTH(CW)) u_coil (
                .vec(coil_img),
                .addr(a),
                .hit(ch),
                .value(cv)
            );
            bit_window #(.WIDTH(DW)) u_di (
                .vec(di_img),
                .addr(a),
                .hit(dh),
                .value(dv)
            );
            assign rd_bits[g] = (16'(g) < count_w) &&
                (is_rd_di ? (dh & dv) : (ch & cv));
        end
    endgenerate

    // write data: one coil from FF00/0000, many from packed bits
    wire [15:0] wr_bits = is_wr_one ? {15'h0000, req_value == `COIL_ON} :
        req_value;
    wire wr_go = req_valid && is_write && range_ok && value_ok &&
        fieldbus_control_enable;

    always_comb begin
        int i;
        int j;
        i = 0;
        j = 0;
        control_d = control_q;
        relay_d = relay_q;
        for (i = 0; i < 16; i++) begin
            j = int'(req_addr) + i;
            if (wr_go && (i < int'(count_w))) begin
                if (j < 32) begin
                    control_d[j[4:0]] = wr_bits[i] & mask_w[j[4:0]];
                end else if (j < CW) begin
                    relay_d[j - 32] = wr_bits[i];
                end
            end
        end
    end

    wire [7:0] exc_w = !fc_ok ? `EXC_FUNCTION :
        !range_ok ? `EXC_ADDRESS :
        !value_ok ? `EXC_VALUE : 8'h00;
    wire refuse_w = is_write && !fieldbus_control_enable;
    // a refused write changes nothing and answers as a function exception, unless an address or value exception comes first
    wire resp_exc_d = (exc_w != 8'h00) || refuse_w;
    wire [7:0] resp_code_d = (exc_w != 8'h00) ? exc_w :
        refuse_w ? `EXC_FUNCTION : req_function;
    wire [4:0] resp_cnt_d = range_ok ? count_w[4:0] : 5'h00;

    always_comb begin
        resp_bits_d = 16'h0000;
        if (is_read && range_ok) begin
            resp_bits_d = rd_bits;
        end else if (is_write) begin
            resp_bits_d = count_w;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            active_q <= `PROF_LIMITED;
            control_q <= 32'h00000000;
            relay_q <= '0;
            status_q <= 32'h00000000;
            di_q <= '0;
        end else begin
            active_q <= prof_w;
            control_q <= control_d & mask_w;
            relay_q <= relay_d;
            status_q <= status_w;
            di_q <= digital_in;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            resp_valid_q <= 1'b0;
            resp_exc_q <= 1'b0;
            resp_code_q <= 8'h00;
            resp_bits_q <= 16'h0000;
            resp_cnt_q <= 5'h00;
        end else begin
            resp_valid_q <= req_valid;
            if (req_valid) begin
                resp_exc_q <= resp_exc_d;
                resp_code_q <= resp_code_d;
                resp_bits_q <= resp_bits_d;
                resp_cnt_q <= resp_cnt_d;
            end
        end
    end

    // limited and full share one command map; active-low stops pass as-is
    wire base_ramp_stop_n = control_q[`CB_STOP_RAMP];
    wire base_coast_stop_n = control_q[`CB_STOP_COAST];
    wire base_emergency_stop_n = control_q[`CB_STOP_EMERGENCY];
    wire base_location_two = control_q[`CB_LOCATION_TWO];
    // extended stop and mode bits are true when set, so they are inverted
    wire ext_ramp_stop_n = !control_q[`CB_EXT_STOP];
    wire ext_coast_stop_n = !control_q[`CB_EXT_COAST_MODE];
    wire ext_emergency_stop_n = !control_q[`CB_EXT_EMERGENCY_MODE];
    wire ext_location_two = control_q[`CB_EXT_LOCATION_TWO];
    wire use_ext_map = (active_q == coil_map_pkg::PROFILE_EXTENDED);
    wire ramp_stop_d = use_ext_map ? ext_ramp_stop_n : base_ramp_stop_n;
    wire coast_stop_d = use_ext_map ? ext_coast_stop_n : base_coast_stop_n;
    wire emergency_stop_d = use_ext_map ? ext_emergency_stop_n :
        base_emergency_stop_n;
    wire location_two_d = use_ext_map ? ext_location_two : base_location_two;

    // stops released in reset; the extra stage keeps the outputs registered
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sig_rs_q <= 1'b1;
            sig_cs_q <= 1'b1;
            sig_es_q <= 1'b1;
            sig_ext_q <= 1'b0;
        end else begin
            sig_rs_q <= ramp_stop_d;
            sig_cs_q <= coast_stop_d;
            sig_es_q <= emergency_stop_d;
            sig_ext_q <= location_two_d;
        end
    end

    assign control_word = control_q;
    assign relay_out = relay_q;
    assign active_profile = active_q;
    assign ramp_stop_n = sig_rs_q;
    assign coast_stop_n = sig_cs_q;
    assign emergency_stop_n = sig_es_q;
    assign external_location_two = sig_ext_q;
    assign resp_valid = resp_valid_q;
    assign resp_exception = resp_exc_q;
    assign resp_code = resp_code_q;
    assign resp_bits = resp_bits_q;
    assign resp_bit_count = resp_cnt_q;
endmodule : fieldbus_coil_profile_mapper
